// File: design/eep_spi_slave.sv
/*
  Serial EEPROM slave front end: samples the SPI pins with the system
  clock, decodes instructions, stages page writes in a page buffer and
  runs the self-timed write cycle into the byte array.
  Assumes sys_clk is far faster than the serial clock (about 16x) and
  that the SPI pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eep_params.svh"

// Contract
// RL1: Works in SPI mode 0 and mode 3; master uses one of them.
// RL2: Array holds 8192 bytes, grouped in 32-byte pages for writing.
// RL3: Byte, partial page or full page writes; master stays within a page.
// RL4: Self-timed programming after a write finishes within 5 ms.
// RL5: Protection guards upper quarter, upper half or all of the array.
// RL6: Under reset instructions are ignored; release gives a fresh standby.
// RL7: Ending a transfer reaches standby only after any write cycle ends.
// RL8: First byte after chip select falls is the op-code and is decoded.
// RL9: Master sends only valid op-codes; unknown codes are undefined.
// RL10: All op-code, address and data bits travel MSB first.
// RL11: Master starts an instruction by pulling chip select low and holding.
// RL12: Chip select rising ends the operation and starts write programming.
// RL13: In standby with chip select high the data output is floating.
// RL14: Input sampled on rising clock, output changes on falling clock.
// RL15: Hold suspends the sequence; release resumes at the same bit.
// RL16: Master moves hold only while the serial clock is low.
// RL17: Inactive chip select clears bit counter and instruction decoder.
// RL18: During a write cycle busy stays high; no new array change starts.
module eep_spi_slave #(
  parameter int WR_CYCLES = `EEP_T_WR_NS / `EEP_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  input wire logic spi_hold_n,
  output logic spi_so,
  output logic spi_so_oe,
  output logic busy
);
  import eep_pkg::*;

  eep_state_s st_q;
  eep_state_s st_d;
  logic sck_rise;
  logic sck_fall;
  logic buf_we;
  logic [4:0] buf_wa;
  logic [7:0] buf_wd;
  logic [7:0] buf_rd;
  logic arr_we;
  logic [12:0] arr_wa;
  logic [7:0] arr_rd;
  logic [7:0] src;
  logic [4:0] j;

  // Glitch filter: a new level counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    filt = (s[1] == s[2]) ? s[2] : f;
  endfunction : filt

  // Upper quarter, upper half or whole array by protection level
  function automatic logic prot(input logic [1:0] bp, input logic [12:0] a);
    case (bp)
      `EEP_BP_QTR: prot = (a[12:11] == 2'h3);
      `EEP_BP_HALF: prot = a[12];
      `EEP_BP_ALL: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction : prot

  // Page buffer collects data bytes until chip select rises
  eep_mem #(.DW(8), .AW(`EEP_PAGE_W)) u_page (
    .clk(sys_clk),
    .we(buf_we),
    .waddr(buf_wa),
    .wdata(buf_wd),
    .raddr(st_q.wc_cnt[4:0]),
    .rdata(buf_rd)
  );

  // Byte array; read address follows the running address
  eep_mem #(.DW(`EEP_DATA_W), .AW(`EEP_ADDR_W)) u_array ( // RL2
    .clk(sys_clk),
    .we(arr_we),
    .waddr(arr_wa),
    .wdata(buf_rd),
    .raddr(st_q.addr),
    .rdata(arr_rd)
  );

  // Whole next-state computation of the front end
  always_comb begin
    st_d = st_q;
    buf_we = 1'b0;
    buf_wa = st_q.addr[4:0];
    buf_wd = 8'h00;
    arr_we = 1'b0;
    j = 5'h00;
    arr_wa = {st_q.page, j};
    src = 8'h00;
    st_d.cs_s = {st_q.cs_s[1:0], spi_cs_n};
    st_d.sck_s = {st_q.sck_s[1:0], spi_sck};
    st_d.si_s = {st_q.si_s[1:0], spi_si};
    st_d.hold_s = {st_q.hold_s[1:0], spi_hold_n};
    st_d.cs_f = filt(st_q.cs_s, st_q.cs_f);
    st_d.sck_f = filt(st_q.sck_s, st_q.sck_f);
    st_d.si_f = filt(st_q.si_s, st_q.si_f);
    st_d.hold_f = filt(st_q.hold_s, st_q.hold_f);
    // Edges only count while selected and not on hold; idle level is free
    sck_rise = st_d.sck_f & ~st_q.sck_f & ~st_d.cs_f & st_d.hold_f; // RL15 RL1
    sck_fall = ~st_d.sck_f & st_q.sck_f & ~st_d.cs_f & st_d.hold_f; // RL15

    // Self-timed write: counts 1 to 32 move the page, then wait out
    if (st_q.busy) begin
      st_d.wc_cnt = st_q.wc_cnt + 20'h00001;
      if (st_q.wc_cnt != 20'h00000 && st_q.wc_cnt <= `EEP_PAGE_LAST + 12) begin
        j = 5'(st_q.wc_cnt - 20'h00001);
        arr_wa = {st_q.page, j};
        arr_we = st_q.mask[j] & ~prot(st_q.bp, arr_wa); // RL5
      end
      if (st_q.wc_cnt == 20'(WR_CYCLES - 1)) begin
        st_d.busy = 1'b0; // RL4
      end
    end

    if (st_d.cs_f) begin
      // Chip select rise ends the frame and may launch programming
      if (!st_q.cs_f && !st_q.busy) begin // RL18
        if (st_q.ph == PH_WDATA && st_q.mask != 32'h00000000) begin
          st_d.busy = 1'b1; // RL12
          st_d.wc_cnt = 20'h00000;
          st_d.wel = 1'b0;
        end else if (st_q.ph == PH_SRW && st_q.sr_pend) begin
          st_d.bp = st_q.sr_new[`EEP_SR_BP_LSB +: 2];
          st_d.busy = 1'b1; // RL12
          st_d.wc_cnt = 20'h00000;
          st_d.mask = 32'h00000000;
          st_d.wel = 1'b0;
        end
      end
      // Fresh op-code byte on next select; writes run on regardless
      st_d.ph = PH_CMD; // RL17 RL7
      st_d.bit_cnt = 3'h0; // RL17
      st_d.out_cnt = 3'h0;
      st_d.out_on = 1'b0;
      st_d.adr_lo = 1'b0;
      st_d.sr_pend = 1'b0;
    end else if (sck_rise) begin
      st_d.rx = {st_q.rx[6:0], st_d.si_f}; // RL10 RL14
      st_d.bit_cnt = st_q.bit_cnt + 3'h1;
      if (st_q.bit_cnt == 3'h7) begin
        case (st_q.ph)
          PH_CMD: begin
            st_d.op = st_d.rx; // RL8
            st_d.ph = PH_SKIP;
            // While busy only the status read is honoured
            if (!st_q.busy || st_d.rx == `EEP_OP_RDSR) begin // RL18
              case (st_d.rx)
                `EEP_OP_WREN: st_d.wel = 1'b1;
                `EEP_OP_WRDI: st_d.wel = 1'b0;
                `EEP_OP_RDSR: st_d.ph = PH_SRR;
                `EEP_OP_WRSR: st_d.ph = st_q.wel ? PH_SRW : PH_SKIP;
                `EEP_OP_READ: st_d.ph = PH_ADDR;
                `EEP_OP_WRITE: st_d.ph = st_q.wel ? PH_ADDR : PH_SKIP;
                default: st_d.ph = PH_SKIP; // RL9
              endcase
            end
          end
          PH_ADDR: begin
            st_d.adr_lo = 1'b1;
            if (!st_q.adr_lo) begin
              st_d.addr[12:8] = st_d.rx[4:0];
            end else begin
              st_d.addr[7:0] = st_d.rx;
              st_d.page = {st_q.addr[12:8], st_d.rx[7:5]};
              st_d.mask = 32'h00000000;
              st_d.ph = (st_q.op == `EEP_OP_READ) ? PH_RDATA : PH_WDATA;
            end
          end
          PH_WDATA: begin
            // Stay inside the page: low address bits wrap
            buf_we = 1'b1; // RL3
            buf_wd = st_d.rx;
            st_d.mask[st_q.addr[4:0]] = 1'b1;
            st_d.addr[4:0] = st_q.addr[4:0] + 5'h01;
          end
          PH_SRW: begin
            st_d.sr_new = st_d.rx;
            st_d.sr_pend = 1'b1;
          end
          default: st_d.ph = st_q.ph;
        endcase
      end
    end else if (sck_fall && (st_q.ph == PH_RDATA || st_q.ph == PH_SRR)) begin
      // Output moves on falling edges, MSB of each byte first
      src = (st_q.ph == PH_RDATA) ? arr_rd :
            {4'h0, st_q.bp, st_q.wel, st_q.busy};
      if (st_q.out_cnt == 3'h0) begin
        st_d.so = src[7]; // RL14 RL10
        st_d.tx = {src[6:0], 1'b0};
      end else begin
        st_d.so = st_q.tx[7]; // RL14 RL10
        st_d.tx = {st_q.tx[6:0], 1'b0};
      end
      st_d.out_cnt = st_q.out_cnt + 3'h1;
      st_d.out_on = 1'b1;
      if (st_q.out_cnt == 3'h7 && st_q.ph == PH_RDATA) begin
        st_d.addr = st_q.addr + 13'h0001;
      end
    end
    // Drive only while selected, not held and in an output phase
    st_d.so_oe = ~st_d.cs_f & st_d.hold_f & st_d.out_on; // RL13 RL15
  end

  // State register; reset forces deselected standby
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{cs_s: 3'h7, cs_f: 1'b1, hold_s: 3'h7, hold_f: 1'b1,
                ph: PH_CMD, default: '0}; // RL6
    end else begin
      st_q <= st_d;
    end
  end

  assign spi_so = st_q.so;
  assign spi_so_oe = st_q.so_oe;
  assign busy = st_q.busy;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence wr_launch;
    st_q.cs_f && !$past(st_q.cs_f) && st_q.busy && st_q.wc_cnt == 20'h0;
  endsequence

  sequence wr_running;
    st_q.busy && st_q.wc_cnt == 20'h1;
  endsequence

  so_float_a: assert property (st_q.so_oe |-> !st_q.cs_f) // RL13
    else $error("data output driven while deselected");
  hold_quiet_a: assert property (st_q.so_oe |-> st_q.hold_f) // RL15
    else $error("data output driven during hold");
  wr_bound_a: assert property ( // RL4
    st_q.busy |-> st_q.wc_cnt < 20'(WR_CYCLES))
    else $error("write cycle overran");
  wr_start_a: assert property (wr_launch |=> wr_running) // RL12
    else $error("write cycle did not advance after select rose");
  prot_guard_a: assert property (arr_we |-> !prot(st_q.bp, arr_wa)) // RL5
    else $error("protected byte written");
  busy_only_a: assert property (arr_we |-> st_q.busy) // RL18
    else $error("array changed outside a write cycle");
  cs_clear_a: assert property (st_q.cs_f |-> st_q.bit_cnt == 3'h0 &&
                               st_q.ph == PH_CMD) // RL17
    else $error("decoder not cleared while deselected");
  msb_first_a: assert property (sck_rise && !st_d.cs_f |=>
    st_q.rx[7:1] == $past(st_q.rx[6:0])) // RL10
    else $error("input not shifted MSB first");
  so_fall_a: assert property ($changed(st_q.so) |-> $past(sck_fall)) // RL14
    else $error("data output moved off a falling edge");
  page_mark_a: assert property (buf_we |=> st_q.mask[$past(buf_wa)]) // RL3
    else $error("page byte not recorded");

endmodule : eep_spi_slave

`default_nettype wire

// File: common/eep_params.svh
/*
  Constants of the serial EEPROM slave front end: array geometry,
  instruction codes, protection levels and write cycle timing.
  Assumes the including file supplies nothing; definitions only.
*/
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

// Array geometry
`define EEP_DATA_W 8
`define EEP_ADDR_W 13
`define EEP_PAGE_W 5
`define EEP_PAGE_LAST 20

// Instruction codes
`define EEP_OP_WREN 8'h06
`define EEP_OP_WRDI 8'h04
`define EEP_OP_RDSR 8'h05
`define EEP_OP_WRSR 8'h01
`define EEP_OP_READ 8'h03
`define EEP_OP_WRITE 8'h02

// Block protection levels and status bit positions
`define EEP_BP_NONE 2'h0
`define EEP_BP_QTR 2'h1
`define EEP_BP_HALF 2'h2
`define EEP_BP_ALL 2'h3
`define EEP_SR_BP_LSB 2

// Self-timed write cycle, in ns, and the system clock period in ns
`define EEP_T_WR_NS 5000000
`define EEP_CLK_NS 10

`endif

// File: common/eep_pkg.sv
/*
  Types of the serial EEPROM slave: serial phase enumeration and the
  packed state record of the front end.
  Assumes eep_params.svh is on the include path.
*/
`include "eep_params.svh"

package eep_pkg;

  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_WDATA, PH_RDATA, PH_SRW, PH_SRR, PH_SKIP
  } eep_phase_e;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [2:0] si_s;
    logic [2:0] hold_s;
    logic cs_f;
    logic sck_f;
    logic si_f;
    logic hold_f;
    eep_phase_e ph;
    logic [7:0] op;
    logic [2:0] bit_cnt;
    logic [2:0] out_cnt;
    logic out_on;
    logic [7:0] rx;
    logic [7:0] tx;
    logic adr_lo;
    logic [12:0] addr;
    logic [7:0] page;
    logic [31:0] mask;
    logic [7:0] sr_new;
    logic sr_pend;
    logic wel;
    logic [1:0] bp;
    logic busy;
    logic [19:0] wc_cnt;
    logic so;
    logic so_oe;
  } eep_state_s;

endpackage : eep_pkg

// File: design/eep_mem.sv
/*
  Simple synchronous memory: one write port, one read port whose data
  come out of a register one clock after the address.
  Assumes a single clock; contents are undefined after power-up.
*/
`timescale 1ns/1ps
`default_nettype none

module eep_mem #(
  parameter int DW = 8,
  parameter int AW = 13
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset: array contents are non-volatile in spirit
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : eep_mem

`default_nettype wire

// File: bench/eep_host.sv
/*
  SPI master model that drives the EEPROM pins in mode 0 or mode 3.
  Assumes clk is the bench clock and that tb calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none

module eep_host (
  input wire logic clk,
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic m3;

  // Deselected, hold released
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    m3 = 1'b0;
  end

  // Half an SCK period is 8 clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Clock settles at its idle level before select falls
  task automatic open(input logic mode);
    m3 = mode;
    sck <= mode;
    tick(8);
    cs_n <= 1'b0;
    tick(8);
  endtask : open

  // SI moves in the low phase so it is stable around each rise
  task automatic shift(input int n, input logic [7:0] t,
                       output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck <= 1'b0;
      si <= t[i];
      tick(8);
      r = {r[6:0], so};
      sck <= 1'b1;
      tick(8);
    end
  endtask : shift

  // Released SI is inverted so no stale bit can pass for data
  task automatic close;
    sck <= m3;
    tick(8);
    cs_n <= 1'b1;
    si <= ~si;
    tick(8);
  endtask : close

  // Hold moves only with SCK low; clock pulses meanwhile must be ignored
  task automatic pause;
    sck <= 1'b0;
    tick(8);
    hold_n <= 1'b0;
    repeat (2) begin
      tick(8);
      sck <= 1'b1;
      si <= ~si;
      tick(8);
      sck <= 1'b0;
    end
    tick(8);
    hold_n <= 1'b1;
    tick(8);
  endtask : pause
endmodule : eep_host

`default_nettype wire

// File: bench/tb.sv
/*
  Self-checking bench of eep_spi_slave against a byte-level model.
  Assumes eep_host drives the pins and common/ is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eep_params.svh"

module tb;
  localparam int WRC = 600;
  logic sys_clk, reset_n, cs_n, sck, si, hold_n, so, so_oe, busy, wel;
  wire logic so_w;
  logic [7:0] mem [int];
  logic [7:0] r;
  logic [1:0] bp;
  logic [12:0] a;
  logic [12:0] pa [5] = '{13'h0000, 13'h0FFF, 13'h1000, 13'h17FF, 13'h1800};
  int num_errors = 0;
  int checks_done = 0;
  int n;

  // Released SO floats
  assign so_w = so_oe ? so : 1'bz;

  eep_spi_slave #(.WR_CYCLES(WRC)) eep_spi_slave_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si),
    .spi_hold_n(hold_n), .spi_so(so), .spi_so_oe(so_oe), .busy(busy));
  eep_host eep_host_inst (.clk(sys_clk), .so(so_w), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string s, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  function automatic logic prot(input logic [12:0] x);
    return bp == 2'h3 || (bp == 2'h2 && x[12]) || (bp == 2'h1 && &x[12:11]);
  endfunction : prot

  task automatic op(input logic [7:0] c, input logic m);
    eep_host_inst.open(m);
    eep_host_inst.shift(8, c, r);
  endtask : op

  task automatic adr(input logic [12:0] x);
    eep_host_inst.shift(8, {3'h0, x[12:8]}, r);
    eep_host_inst.shift(8, x[7:0], r);
  endtask : adr

  task automatic one(input logic [7:0] c);
    op(c, 1'b0);
    eep_host_inst.close();
  endtask : one

  task automatic rdsr(input logic m, input logic bz);
    op(`EEP_OP_RDSR, m);
    eep_host_inst.shift(8, 8'h00, r);
    eep_host_inst.close();
    check("status", r, {4'h0, bp, wel, bz});
    check("float", so_oe, 1'b0);
  endtask : rdsr

  // Data bytes wrap inside the page; protected slots keep old contents
  task automatic wr(input logic [12:0] x, input int k, input logic pz);
    logic [7:0] d;
    logic [12:0] y;
    one(`EEP_OP_WREN);
    op(`EEP_OP_WRITE, 1'b0);
    adr(x);
    for (int i = 0; i < k; i++) begin
      d = 8'($urandom);
      y = {x[12:5], 5'(x[4:0] + i)};
      eep_host_inst.shift(4, d, r);
      if (pz) eep_host_inst.pause();
      eep_host_inst.shift(4, d << 4, r);
      if (!prot(y)) mem[int'(y)] = d;
    end
    eep_host_inst.close();
    wel = 1'b0;
    if (!prot(x)) check("busy", busy, 1'b1);
  endtask : wr

  task automatic idle;
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    // A write cycle that never ends counts as a mismatch here
    check("ready", busy, 1'b0);
  endtask : idle

  task automatic rd(input logic [12:0] x, input int k, input logic m);
    op(`EEP_OP_READ, m);
    adr(x);
    for (int i = 0; i < k; i++) begin
      eep_host_inst.shift(8, 8'($urandom), r);
      if (mem.exists(int'(13'(x + i)))) begin
        check("data", r, mem[int'(13'(x + i))]);
      end
    end
    eep_host_inst.close();
  endtask : rd

  // Watchdog: the sequence needs about 50000 clocks
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    bp = 2'h0;
    wel = 1'b0;
    void'($urandom(74));
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("idle", {so_oe, busy}, 2'b00);
    rdsr(1'b0, 1'b0);
    // Wrapping page write with a hold in every byte, read in mode 3
    a = 13'($urandom) | 13'h001E;
    wr(a, 4, 1'b1);
    idle();
    check("wtime", n >= WRC - 8 && n <= WRC, 1'b1);
    rd({a[12:5], 5'h00}, 32, 1'b1);
    // While busy only status reads count
    wr(a, 1, 1'b0);
    rdsr(1'b1, 1'b1);
    one(`EEP_OP_WREN);
    idle();
    rdsr(1'b0, 1'b0);
    // Aborted op-code and partial data byte start nothing
    one(`EEP_OP_WREN);
    wel = 1'b1;
    eep_host_inst.open(1'b0);
    eep_host_inst.shift(3, `EEP_OP_WRITE, r);
    eep_host_inst.close();
    op(`EEP_OP_WRITE, 1'b0);
    adr(a);
    eep_host_inst.shift(5, 8'hA5, r);
    eep_host_inst.close();
    check("nobusy", busy, 1'b0);
    rdsr(1'b0, 1'b0);
    one(`EEP_OP_WRDI);
    wel = 1'b0;
    rdsr(1'b1, 1'b0);
    // A write without the enable latch set must not start programming
    op(`EEP_OP_WRITE, 1'b0);
    adr(a);
    eep_host_inst.shift(8, 8'($urandom), r);
    eep_host_inst.close();
    check("nowel", busy, 1'b0);
    // Every protection level against both sides of each boundary
    for (int b = 0; b < 4; b++) begin
      one(`EEP_OP_WREN);
      op(`EEP_OP_WRSR, 1'b0);
      eep_host_inst.shift(8, 8'(b << `EEP_SR_BP_LSB), r);
      eep_host_inst.close();
      bp = 2'(b);
      wel = 1'b0;
      idle();
      rdsr(1'b1, 1'b0);
      foreach (pa[j]) begin
        wr(pa[j], 1, 1'b0);
        idle();
        rd(pa[j], 1, 1'b0);
      end
    end
    // Reset in mid-run: a frame sent under reset is ignored, state restarts
    reset_n <= 1'b0;
    bp = 2'h0;
    one(`EEP_OP_WREN);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("rst", {so_oe, busy}, 2'b00);
    rdsr(1'b0, 1'b0);
    rd(pa[0], 1, 1'b0);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
